// ==== core/fepd_power_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module fepd_power_ctrl #(
    parameter int DLY_W = 5
) (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       ce_i,
    input  wire logic       duplex_sel_i,
    input  wire logic       power_select_pin_i,
    input  wire logic       tx_burst_gate_i,
    input  wire logic       rx_burst_gate_i,
    input  wire logic       tx_silence_pin_n_i,
    input  wire logic       tx_word_clock_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sdi_i,
    output logic            spi_sdo_o,
    output logic            spi_sdo_oe_n_o,
    output logic [7:0]      block_pd_o,
    output logic            line_driver_amp_pd_o,
    output logic            interp_disable_o,
    output logic            interp_flush_o
);
    import fepd_pkg::*;

    if (DLY_W != HD_DLY_MSB - HD_DLY_LSB + 1) begin : g_chk
        $error("DLY_W must match the delay field");
    end

    function automatic logic rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // ****************
    // Registers and strap
    // ****************
    logic [7:0]       mask_a_r;
    logic [7:0]       mask_b_r;
    logic [7:0]       hd_ctrl_r;
    logic             hd_mode_r;
    logic             strap_done_r;
    logic             sclk_q;
    logic [15:0]      sh_r;
    logic [3:0]       bit_cnt_r;
    logic [7:0]       rd_sh_r;
    logic             rd_act_r;
    logic             sck_rise;
    logic             sck_fall;
    logic             wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]       wr_data;

    function automatic logic [7:0] reg_rd(input logic [ADDR_W-1:0] a,
                                          input logic [7:0] ma,
                                          input logic [7:0] mb,
                                          input logic [7:0] hc);
        case (a)
            REG_MASK_A:  return ma;
            REG_MASK_B:  return mb;
            REG_HD_CTRL: return hc;
            default:     return 8'h00;
        endcase
    endfunction

    assign sck_rise = rise(spi_sclk_i, sclk_q);
    assign sck_fall = rise(sclk_q, spi_sclk_i);
    assign wr_stb   = sck_rise & ~spi_cs_n_i & (bit_cnt_r == 4'hF) & ~sh_r[14];
    assign wr_addr  = sh_r[13:7];
    assign wr_data  = {sh_r[6:0], spi_sdi_i};

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q    <= 1'b0;
            sh_r      <= 16'h0000;
            bit_cnt_r <= 4'h0;
            rd_sh_r   <= 8'h00;
            rd_act_r  <= 1'b0;
        end else if (ce_i) begin
            sclk_q <= spi_sclk_i;
            if (spi_cs_n_i) begin
                bit_cnt_r <= 4'h0;
                rd_act_r  <= 1'b0;
            end else if (sck_rise) begin
                sh_r      <= {sh_r[14:0], spi_sdi_i};
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (bit_cnt_r == 4'h7) begin
                    rd_act_r <= sh_r[6];
                    rd_sh_r  <= reg_rd({sh_r[5:0], spi_sdi_i}, mask_a_r, mask_b_r, hd_ctrl_r);
                end
            end else if (sck_fall && rd_act_r && bit_cnt_r >= 4'h9) begin
                rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
        end
    end

    assign spi_sdo_o      = rd_sh_r[7];
    assign spi_sdo_oe_n_o = ~(rd_act_r & ~spi_cs_n_i);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mask_a_r  <= MASK_A_RST; // [RULE4]
            mask_b_r  <= MASK_B_RST; // [RULE4]
            hd_ctrl_r <= HD_CTRL_RST; // [RULE15]
        end else if (ce_i && wr_stb) begin
            if (wr_addr == REG_MASK_A) begin
                mask_a_r <= wr_data;
            end
            if (wr_addr == REG_MASK_B) begin
                mask_b_r <= wr_data;
            end
            if (wr_addr == REG_HD_CTRL) begin
                hd_ctrl_r <= wr_data;
            end
        end
    end

    // Strap caught on the first enabled edge after release
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hd_mode_r    <= 1'b1;
            strap_done_r <= 1'b0;
        end else if (ce_i && !strap_done_r) begin
            hd_mode_r    <= ~duplex_sel_i; // [RULE21]
            strap_done_r <= 1'b1;
        end
    end

    // ****************
    // Burst gate edges
    // ****************
    logic             tx_q;
    logic             rx_q;
    logic             wclk_q;
    logic             tx_rise;
    logic             tx_fall;
    logic             rx_rise;
    logic             rx_fall;
    logic             wclk_rise;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_q   <= 1'b0;
            rx_q   <= 1'b0;
            wclk_q <= 1'b0;
        end else if (ce_i) begin
            tx_q   <= tx_burst_gate_i;
            rx_q   <= rx_burst_gate_i;
            wclk_q <= tx_word_clock_i;
        end
    end

    assign tx_rise   = rise(tx_burst_gate_i, tx_q); // [RULE23]
    assign tx_fall   = rise(tx_q, tx_burst_gate_i); // [RULE23]
    assign rx_rise   = rise(rx_burst_gate_i, rx_q);
    assign rx_fall   = rise(rx_q, rx_burst_gate_i);
    assign wclk_rise = rise(tx_word_clock_i, wclk_q);

    // ****************
    // Tx delayed shutdown and flush
    // ****************
    logic [DLY_W-1:0] dly_cnt_r;
    logic             dly_run_r;
    logic             tx_off_r;
    logic [5:0]       fl_cnt_r;
    logic [DLY_W-1:0] dly_cfg;

    assign dly_cfg = hd_ctrl_r[HD_DLY_MSB:HD_DLY_LSB];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dly_cnt_r <= '0;
            dly_run_r <= 1'b0;
            tx_off_r  <= 1'b1;
        end else if (ce_i) begin
            if (tx_rise) begin
                dly_run_r <= 1'b0; // [RULE17]
                tx_off_r  <= 1'b0; // [RULE17]
            end else if (tx_fall) begin
                dly_cnt_r <= dly_cfg; // [RULE14] [RULE15]
                dly_run_r <= (dly_cfg != '0);
                tx_off_r  <= (dly_cfg == '0);
            end else if (dly_run_r && wclk_rise) begin
                dly_cnt_r <= dly_cnt_r - 1'b1; // [RULE15]
                if (dly_cnt_r == 1) begin
                    dly_run_r <= 1'b0;
                    tx_off_r  <= 1'b1; // [RULE14]
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fl_cnt_r <= 6'h00;
        end else if (ce_i) begin
            if (tx_rise) begin
                fl_cnt_r <= 6'h00;
            end else if (tx_fall) begin
                fl_cnt_r <= FLUSH_WCLK; // [RULE16]
            end else if (fl_cnt_r != 6'h00 && wclk_rise) begin
                fl_cnt_r <= fl_cnt_r - 6'h01; // [RULE16]
            end
        end
    end

    // ****************
    // Rx path burst control
    // ****************
    logic rx_off_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_off_r <= 1'b0;
        end else if (ce_i) begin
            if (hd_ctrl_r[HD_RXSEL]) begin
                if (rx_rise) begin
                    rx_off_r <= 1'b0; // [RULE19]
                end else if (rx_fall) begin
                    rx_off_r <= 1'b1; // [RULE19]
                end
            end else if (tx_rise) begin
                rx_off_r <= 1'b1; // [RULE18] [RULE8]
            end else if (tx_fall) begin
                rx_off_r <= 1'b0; // [RULE18] [RULE9]
            end
        end
    end

    // ****************
    // Power-down combining
    // ****************
    logic [7:0] sel_mask;
    logic [7:0] burst_pd;
    logic       drv_burst;
    logic       quiet;
    logic       tx_fast;
    logic       rx_fast;

    assign sel_mask  = power_select_pin_i ? mask_b_r : mask_a_r; // [RULE1] [RULE2] [RULE3]
    assign tx_fast   = hd_mode_r & hd_ctrl_r[HD_TX_BURST_GATE]; // [RULE12] [RULE20]
    assign rx_fast   = hd_mode_r & hd_ctrl_r[HD_RX_BURST_GATE]; // [RULE12] [RULE20]
    assign drv_burst = tx_fast & tx_off_r; // [RULE13]
    assign quiet     = ~hd_mode_r & ~tx_silence_pin_n_i; // [RULE10]

    always_comb begin
        burst_pd             = 8'h00; // [RULE6]
        burst_pd[BIT_TXDIG]  = drv_burst & (fl_cnt_r == 6'h00); // [RULE16]
        burst_pd[BIT_RXCONV] = rx_fast & rx_off_r;
        burst_pd[BIT_RXAMP]  = rx_fast & rx_off_r;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            block_pd_o           <= MASK_A_RST;
            line_driver_amp_pd_o <= 1'b0;
            interp_disable_o     <= 1'b0;
            interp_flush_o       <= 1'b0;
        end else if (ce_i) begin
            block_pd_o           <= sel_mask | burst_pd; // [RULE22] [RULE5]
            line_driver_amp_pd_o <= sel_mask[BIT_TXCONV] | drv_burst | quiet; // [RULE22]
            interp_disable_o     <= quiet | sel_mask[BIT_TXDIG] | burst_pd[BIT_TXDIG]; // [RULE10]
            interp_flush_o       <= (fl_cnt_r != 6'h00) & tx_fast;
        end
    end

    // ****************
    // Assertions
    // ****************
    localparam int FAST_C = FAST_OFF_CYC;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_tx_fall;
        ce_i && tx_fall && !tx_rise;
    endsequence
    sequence s_dly_fire;
        ce_i && dly_run_r && wclk_rise && dly_cnt_r == 1 && !tx_rise && !tx_fall;
    endsequence

    AST_MASK_A: assert property (ce_i && !power_select_pin_i |=> // [RULE1]
        (block_pd_o & $past(mask_a_r)) == $past(mask_a_r))
        else $error("first mask not applied");
    AST_MASK_B: assert property (ce_i && power_select_pin_i |=> // [RULE2]
        (block_pd_o & $past(mask_b_r)) == $past(mask_b_r))
        else $error("second mask not applied");
    AST_DLY_LOAD: assert property (s_tx_fall ##0 dly_cfg != '0 |=> // [RULE15]
        dly_run_r && dly_cnt_r == $past(dly_cfg) && !tx_off_r)
        else $error("delay not loaded on gate fall");
    AST_TX_OFF: assert property (s_dly_fire ##0 tx_fast && !quiet // [RULE14]
        |-> ##[1:FAST_C] line_driver_amp_pd_o)
        else $error("line driver not off after delay");
    AST_TX_ON: assert property (ce_i && tx_rise |=> !tx_off_r && !dly_run_r) // [RULE17]
        else $error("tx not powered up on gate rise");
    AST_FLUSH: assert property (s_tx_fall |=> fl_cnt_r == FLUSH_WCLK) // [RULE16]
        else $error("flush count not loaded");
    AST_FLUSH_HOLD: assert property (ce_i && fl_cnt_r != 6'h00 && !sel_mask[BIT_TXDIG] // [RULE16]
        |=> !block_pd_o[BIT_TXDIG])
        else $error("tx digital off during flush");
    AST_RX_TXSEL: assert property (ce_i && !hd_ctrl_r[HD_RXSEL] && tx_fall // [RULE18]
        |=> !rx_off_r)
        else $error("rx not on after tx gate fall");
    AST_RX_RXSEL: assert property (ce_i && hd_ctrl_r[HD_RXSEL] && rx_fall // [RULE19]
        |=> rx_off_r)
        else $error("rx not off after rx gate fall");
    AST_QUIET: assert property (ce_i && quiet |=> // [RULE10]
        line_driver_amp_pd_o && interp_disable_o)
        else $error("silence pin ignored");
    AST_HD_ONLY: assert property (ce_i && !hd_mode_r // [RULE12]
        |=> block_pd_o == $past(sel_mask))
        else $error("burst control active outside half duplex");
endmodule
`default_nettype wire

// ==== core/fepd_pkg.sv ====
// Contract
// RULE1: Select pin low: first mask powers blocks down
// RULE2: Select pin high: second mask powers blocks down
// RULE3: Select pin acts at once, no write needed
// RULE4: Reset: first mask zero, second all but synthesizer
// RULE5: Shared bit map, synthesizer bit 7 down to amplifier
// RULE6: Only four blocks get fast burst switching
// RULE7: Full duplex: software programs complementary path masks
// RULE8: Tx burst: rx off 100 ns, tx on 0.5 us
// RULE9: Rx burst: tx off 100 ns, rx on 2 us
// RULE10: Silence pin low: line driver off, filter disabled (the code does this only in full duplex; the pin is ignored in half duplex)
// RULE11: Controller flushes filter with zeros around power-down
// RULE12: Half-duplex control register acts only in half duplex
// RULE13: Default half duplex: tx gate controls, converter stays
// RULE14: Tx gate fall starts delayed shutdown, then off quickly
// RULE15: Five-bit delay in word clocks, reset value 31
// RULE16: Midscale flush for 33 word clocks before power-down
// RULE17: Tx gate rise powers tx up without delay
// RULE18: Default: tx gate fall rx on, rise rx off
// RULE19: Rx select: rx gate rise on, fall off
// RULE20: Clear enable bits to disable fast power-down
// RULE21: Duplex strap low half duplex, high full duplex
// RULE22: Block off when any active source asks it
// RULE23: Gate edges found synchronously before delay counter starts
package fepd_pkg;
    // ****************
    // Register map
    // ****************
    localparam int          ADDR_W      = 7;
    localparam logic [6:0]  REG_MASK_A  = 7'h01;
    localparam logic [6:0]  REG_MASK_B  = 7'h02;
    localparam logic [6:0]  REG_HD_CTRL = 7'h03;
    localparam logic [7:0]  MASK_A_RST  = 8'h00;
    localparam logic [7:0]  MASK_B_RST  = 8'h7F;
    localparam logic [7:0]  HD_CTRL_RST = 8'hFB;
    // ****************
    // Bit map of blocks
    // ****************
    localparam int BIT_SYNTH  = 7;
    localparam int BIT_TXCONV = 6;
    localparam int BIT_TXDIG  = 5;
    localparam int BIT_REF    = 4;
    localparam int BIT_CML    = 3;
    localparam int BIT_RXCONV = 2;
    localparam int BIT_BIAS   = 1;
    localparam int BIT_RXAMP  = 0;
    // Half-duplex control fields
    localparam int HD_DLY_MSB = 7;
    localparam int HD_DLY_LSB = 3;
    localparam int HD_RXSEL   = 2;
    localparam int HD_TX_BURST_GATE    = 1;
    localparam int HD_RX_BURST_GATE    = 0;
    // ****************
    // Timing
    // ****************
    localparam int CLK_MHZ      = 20;
    localparam int FAST_OFF_NS  = 100;
    localparam int TX_ON_NS     = 500;
    localparam int RX_ON_NS     = 2000;
    localparam int FAST_OFF_CYC = FAST_OFF_NS * CLK_MHZ / 1000;
    localparam int TX_ON_CYC    = TX_ON_NS * CLK_MHZ / 1000;
    localparam int RX_ON_CYC    = RX_ON_NS * CLK_MHZ / 1000;
    localparam logic [5:0] FLUSH_WCLK = 6'h21;
    localparam int SPI_BITS     = 16;
endpackage

// ==== bench/fepd_baseband_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************
// Far-side controller: word clock source
// ****************
module fepd_baseband_model (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic run_i,
    output var logic  tx_word_clock_o
);
    logic [0:0] div_r;
    // Keeps the word clock running after the gate falls; stands low when idle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_r           <= 1'b0;
            tx_word_clock_o <= 1'b0;
        end else if (run_i) begin
            div_r <= div_r + 1'b1;
            if (div_r == 1'b1) begin
                tx_word_clock_o <= ~tx_word_clock_o;
            end
        end else begin
            tx_word_clock_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import fepd_pkg::*;
    logic clk = 0, rst_n = 0, dsel = 0, psel = 0, txg = 0, rxg = 0, sil_n = 1;
    logic sclk = 0, cs_n = 1, sdi = 0, run = 1, ce = 1, wclk, sdo, oe_n, ld, idis, fl;
    logic [7:0] pd, rv;
    int error_cnt = 0, total_checks = 0;
    always #25 clk = ~clk;
    fepd_baseband_model PM (.clk_i(clk), .reset_n_i(rst_n), .run_i(run),
        .tx_word_clock_o(wclk));
    fepd_power_ctrl DUT (.clk_i(clk), .reset_n_i(rst_n), .ce_i(ce),
        .duplex_sel_i(dsel), .power_select_pin_i(psel), .tx_burst_gate_i(txg),
        .rx_burst_gate_i(rxg), .tx_silence_pin_n_i(sil_n), .tx_word_clock_i(wclk),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_n_o(oe_n), .block_pd_o(pd), .line_driver_amp_pd_o(ld),
        .interp_disable_o(idis), .interp_flush_o(fl));
    // ****************
    // Helpers
    // ****************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic spi(input logic [15:0] fr, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            sdi  <= fr[15-i];
            sclk <= 1'b0;
            step(2);
            if (i >= 8) rd = {rd[6:0], sdo};
            if (i == 12 && fr[15]) chk("sdo_oe_n", 8'h00, {7'h00, oe_n});
            sclk <= 1'b1;
            step(1);
        end
        @(posedge clk) cs_n <= 1'b1;
        step(2);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi({1'b0, a, d}, x);
        step(2);
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] x;
        spi({1'b1, a, 8'h00}, x);
        chk("reg_read", exp, x);
    endtask
    task automatic do_reset(input logic duplex);
        @(posedge clk);
        rst_n <= 1'b0;
        dsel  <= duplex;
        step(4);
        rst_n <= 1'b1;
        step(4);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        #1000000;
        error_cnt++;
        end_sim();
    end
    initial begin
        do_reset(1'b0);
        rdchk(REG_MASK_A, MASK_A_RST);
        rdchk(REG_MASK_B, MASK_B_RST);
        rdchk(REG_HD_CTRL, 8'hFB);
        rdchk(7'h10, 8'h00);
        chk("pd_after_reset", 8'h20, pd);
        chk("ld_after_reset", 8'h01, {7'h00, ld});
        $display("test reset values done");
        wr(REG_MASK_A, 8'h91);
        step(3);
        chk("pd_mask_low", 8'hB1, pd);
        psel <= 1'b1;
        step(3);
        chk("pd_mask_high", 8'h7F, pd);
        psel <= 1'b0;
        wr(REG_MASK_A, 8'h00);
        ce   <= 1'b0;
        psel <= 1'b1;
        step(3);
        chk("pd_ce_low", 8'h20, pd);
        ce <= 1'b1;
        step(3);
        chk("pd_ce_high", 8'h7F, pd);
        psel <= 1'b0;
        $display("test masks done");
        wr(REG_HD_CTRL, 8'h1B);
        txg <= 1'b1;
        step(3);
        chk("pd_tx_burst", 8'h05, pd);
        chk("ld_tx_burst", 8'h00, {7'h00, ld});
        txg <= 1'b0;
        step(3);
        chk("pd_tx_fall", 8'h00, pd);
        chk("ld_in_delay", 8'h00, {7'h00, ld});
        chk("flush_on", 8'h01, {7'h00, fl});
        step(20);
        chk("ld_after_delay", 8'h01, {7'h00, ld});
        step(140);
        chk("pd_after_flush", 8'h20, pd);
        chk("flush_off", 8'h00, {7'h00, fl});
        $display("test tx burst done");
        wr(REG_HD_CTRL, 8'h18);
        step(3);
        chk("pd_fast_off", 8'h00, pd);
        chk("ld_fast_off", 8'h00, {7'h00, ld});
        txg <= 1'b1;
        step(3);
        chk("pd_fast_off_gate", 8'h00, pd);
        wr(REG_HD_CTRL, 8'h1F);
        txg <= 1'b0;
        step(3);
        chk("rx_gate_low", 8'h05, pd & 8'h05);
        rxg <= 1'b1;
        step(3);
        chk("rx_gate_high", 8'h00, pd & 8'h05);
        rxg <= 1'b0;
        step(3);
        chk("rx_gate_fall", 8'h05, pd & 8'h05);
        $display("test rx select done");
        do_reset(1'b1);
        wr(REG_MASK_A, 8'h60);
        wr(REG_MASK_B, 8'h05);
        txg <= 1'b1;
        step(3);
        chk("pd_full_low", 8'h60, pd);
        psel <= 1'b1;
        step(3);
        chk("pd_full_high", 8'h05, pd);
        sil_n <= 1'b0;
        step(3);
        chk("ld_silence", 8'h01, {7'h00, ld});
        chk("interp_silence", 8'h01, {7'h00, idis});
        $display("test full duplex done");
        end_sim();
    end
endmodule
`default_nettype wire
